// *** mte_event_fire.sv ***
// One timed event: fires once per pulse when the count reaches its delay
`timescale 1ns/1ps
`default_nettype none

module mte_event_fire (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      start,
  input  wire logic                      active,
  input  wire logic [mte_pkg::CNT_W-1:0]   count,
  input  wire logic [mte_pkg::FIELD_W-1:0] delay,
  output logic                           fire,
  output logic                           done_q
);

  logic done_d;

  always_comb begin
    fire   = active && !start && !done_q && (count == {1'b0, delay});
    done_d = start ? 1'b0 : (done_q || fire);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

endmodule

`default_nettype wire

// *** mte_pin_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module mte_pin_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  // The first stage feeds only the second stage
  always_comb begin
    level_d = (s2_q == s3_q) ? s2_q : level_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

endmodule

`default_nettype wire

// *** mte_pkg.sv ***
// Constants for the modulation edge timing block
package mte_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int IDX_W  = 7;
  localparam int REG_W  = 8;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CLAMP_RELEASE_TIME  = 7'h34;
  localparam logic [IDX_W-1:0] IDX_MOD_SUPPLY_RES_TIME = 7'h35;
  localparam logic [IDX_W-1:0] IDX_DRV_STOP_RETURN_TIME = 7'h36;
  localparam logic [IDX_W-1:0] IDX_CLAMP_RECONNECT_TIME = 7'h37;
  localparam logic [IDX_W-1:0] IDX_SEQ_STATUS          = 7'h40;

  localparam logic [ADDR_W-1:0] BA_CLAMP_RELEASE_TIME   = {IDX_CLAMP_RELEASE_TIME, 2'b00};
  localparam logic [ADDR_W-1:0] BA_MOD_SUPPLY_RES_TIME  = {IDX_MOD_SUPPLY_RES_TIME, 2'b00};
  localparam logic [ADDR_W-1:0] BA_DRV_STOP_RETURN_TIME = {IDX_DRV_STOP_RETURN_TIME, 2'b00};
  localparam logic [ADDR_W-1:0] BA_CLAMP_RECONNECT_TIME = {IDX_CLAMP_RECONNECT_TIME, 2'b00};
  localparam logic [ADDR_W-1:0] BA_SEQ_STATUS           = {IDX_SEQ_STATUS, 2'b00};

  localparam logic [REG_W-1:0] TIME_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field layout: two 4-bit delay fields in the second and third registers, one low field in the first and fourth
  // ----------------------------------------------------------------
  localparam int FIELD_W  = 4;
  localparam int LO_LSB   = 0;
  localparam int HI_LSB   = 4;

  // Status register bit positions
  localparam int ST_CLAMP_RELEASED = 0;
  localparam int ST_ON_MOD_SUPPLY  = 1;
  localparam int ST_MOD_RESISTANCE = 2;
  localparam int ST_DRIVER_STOPPED = 3;
  localparam int ST_SEQ_ACTIVE     = 4;

  // ----------------------------------------------------------------
  // Carrier period counter
  // ----------------------------------------------------------------
  localparam int               CNT_W   = 5;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h10;
  localparam int               N_EVT   = 6;

endpackage

// *** mte_top.sv ***
// Modulation edge timing: registers and carrier-period event sequencer
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - release clamp after first-register low field
// - switch to modulation supply after second-high field
// - modulation resistance after second-register low field
// - stop driver after third-register high field
// - return to RF supply after third-low field
// - reconnect clamp after fourth-register low field
module mte_top (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic [mte_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [3:0]                 avs_byteenable,
  input  wire logic [mte_pkg::DATA_W-1:0] avs_writedata,
  output logic [mte_pkg::DATA_W-1:0]      avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       mod_pulse_in,
  input  wire logic                       fc_tick,
  output logic                            clamp_released,
  output logic                            on_mod_supply,
  output logic                            mod_resistance,
  output logic                            driver_stopped,
  output logic                            seq_active
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic                       req;
  logic                       ack_q;
  logic                       ack_d;
  logic                       wr_en;
  logic [mte_pkg::DATA_W-1:0] rdata_q;
  logic [mte_pkg::DATA_W-1:0] rdata_d;
  logic [mte_pkg::REG_W-1:0]  t1_q;
  logic [mte_pkg::REG_W-1:0]  t2_q;
  logic [mte_pkg::REG_W-1:0]  t3_q;
  logic [mte_pkg::REG_W-1:0]  t4_q;
  logic [mte_pkg::REG_W-1:0]  t1_d;
  logic [mte_pkg::REG_W-1:0]  t2_d;
  logic [mte_pkg::REG_W-1:0]  t3_d;
  logic [mte_pkg::REG_W-1:0]  t4_d;
  logic [mte_pkg::REG_W-1:0]  status;

  assign req             = avs_read || avs_write;
  // One wait cycle per access, so read data come from a flop
  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata    = rdata_q;
  assign wr_en           = avs_write && ack_q && avs_byteenable[0];

  always_comb begin
    ack_d   = req && !ack_q;
    rdata_d = rdata_q;
    t1_d    = t1_q;
    t2_d    = t2_q;
    t3_d    = t3_q;
    t4_d    = t4_q;
    if (avs_read && !ack_q) begin
      // Unmapped addresses read as zero
      case (avs_address)
        mte_pkg::BA_CLAMP_RELEASE_TIME:   rdata_d = {24'h000000, t1_q};
        mte_pkg::BA_MOD_SUPPLY_RES_TIME:  rdata_d = {24'h000000, t2_q};
        mte_pkg::BA_DRV_STOP_RETURN_TIME: rdata_d = {24'h000000, t3_q};
        mte_pkg::BA_CLAMP_RECONNECT_TIME: rdata_d = {24'h000000, t4_q};
        mte_pkg::BA_SEQ_STATUS:           rdata_d = {24'h000000, status};
        default:                          rdata_d = 32'h00000000;
      endcase
    end
    // Reserved bits are stored as written; software keeps them zero
    if (wr_en) begin
      case (avs_address)
        mte_pkg::BA_CLAMP_RELEASE_TIME:   t1_d = avs_writedata[7:0];
        mte_pkg::BA_MOD_SUPPLY_RES_TIME:  t2_d = avs_writedata[7:0];
        mte_pkg::BA_DRV_STOP_RETURN_TIME: t3_d = avs_writedata[7:0];
        mte_pkg::BA_CLAMP_RECONNECT_TIME: t4_d = avs_writedata[7:0];
        default:                          t1_d = t1_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
      t1_q    <= mte_pkg::TIME_REG_RESET;
      t2_q    <= mte_pkg::TIME_REG_RESET;
      t3_q    <= mte_pkg::TIME_REG_RESET;
      t4_q    <= mte_pkg::TIME_REG_RESET;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      t1_q    <= t1_d;
      t2_q    <= t2_d;
      t3_q    <= t3_d;
      t4_q    <= t4_d;
    end
  end

  // ----------------------------------------------------------------
  // Pulse start detection and carrier period counter
  // ----------------------------------------------------------------
  logic                      mod_lvl_q;
  logic                      mod_prev_q;
  logic                      start;
  logic                      active_q;
  logic                      active_d;
  logic [mte_pkg::CNT_W-1:0] cnt_q;
  logic [mte_pkg::CNT_W-1:0] cnt_d;
  logic [mte_pkg::N_EVT-1:0] fire;
  logic [mte_pkg::N_EVT-1:0] done;

  mte_pin_sync u_mod_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .pin_in  (mod_pulse_in),
    .level_q (mod_lvl_q)
  );

  assign start = mod_lvl_q && !mod_prev_q;

  always_comb begin
    cnt_d    = cnt_q;
    active_d = active_q;
    if (start) begin
      // A new pulse restarts the sequence even if one is running
      cnt_d    = '0;
      active_d = 1'b1;
    end else if (active_q) begin
      // Saturate so a long pulse never wraps back onto an early event
      if (fc_tick && (cnt_q != mte_pkg::CNT_MAX)) begin
        cnt_d = cnt_q + 5'h01;
      end
      if (&(done | fire)) begin
        active_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mod_prev_q <= 1'b0;
      cnt_q      <= '0;
      active_q   <= 1'b0;
    end else begin
      mod_prev_q <= mod_lvl_q;
      cnt_q      <= cnt_d;
      active_q   <= active_d;
    end
  end

  // ----------------------------------------------------------------
  // Timed events
  // ----------------------------------------------------------------
  logic [mte_pkg::FIELD_W-1:0] delay [mte_pkg::N_EVT];

  // 0 clamp release, 1 supply start, 2 resistance, 3 stop, 4 return, 5 reconnect
  assign delay[0] = t1_q[mte_pkg::LO_LSB +: mte_pkg::FIELD_W];
  assign delay[1] = t2_q[mte_pkg::HI_LSB +: mte_pkg::FIELD_W];
  assign delay[2] = t2_q[mte_pkg::LO_LSB +: mte_pkg::FIELD_W];
  assign delay[3] = t3_q[mte_pkg::HI_LSB +: mte_pkg::FIELD_W];
  assign delay[4] = t3_q[mte_pkg::LO_LSB +: mte_pkg::FIELD_W];
  assign delay[5] = t4_q[mte_pkg::LO_LSB +: mte_pkg::FIELD_W];

  for (genvar i = 0; i < mte_pkg::N_EVT; i++) begin : g_evt
    mte_event_fire u_evt (
      .clk    (clk),
      .rst_b  (rst_b),
      .start  (start),
      .active (active_q),
      .count  (cnt_q),
      .delay  (delay[i]),
      .fire   (fire[i]),
      .done_q (done[i])
    );
  end

  // ----------------------------------------------------------------
  // Driver control levels
  // ----------------------------------------------------------------
  logic clamp_q;
  logic clamp_d;
  logic mod_sup_q;
  logic mod_sup_d;
  logic mod_res_q;
  logic mod_res_d;
  logic stop_q;
  logic stop_d;

  // The later event of a pair wins when both fire together
  always_comb begin
    clamp_d   = clamp_q;
    mod_sup_d = mod_sup_q;
    mod_res_d = start ? 1'b0 : mod_res_q;
    stop_d    = start ? 1'b0 : stop_q;
    if (fire[0]) clamp_d = 1'b1;
    if (fire[5]) clamp_d = 1'b0;
    if (fire[1]) mod_sup_d = 1'b1;
    if (fire[4]) mod_sup_d = 1'b0;
    if (fire[2]) mod_res_d = 1'b1;
    if (fire[3]) stop_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clamp_q   <= 1'b0;
      mod_sup_q <= 1'b0;
      mod_res_q <= 1'b0;
      stop_q    <= 1'b0;
    end else begin
      clamp_q   <= clamp_d;
      mod_sup_q <= mod_sup_d;
      mod_res_q <= mod_res_d;
      stop_q    <= stop_d;
    end
  end

  assign clamp_released = clamp_q;
  assign on_mod_supply  = mod_sup_q;
  assign mod_resistance = mod_res_q;
  assign driver_stopped = stop_q;
  assign seq_active     = active_q;

  always_comb begin
    status                             = 8'h00;
    status[mte_pkg::ST_CLAMP_RELEASED] = clamp_q;
    status[mte_pkg::ST_ON_MOD_SUPPLY]  = mod_sup_q;
    status[mte_pkg::ST_MOD_RESISTANCE] = mod_res_q;
    status[mte_pkg::ST_DRIVER_STOPPED] = stop_q;
    status[mte_pkg::ST_SEQ_ACTIVE]     = active_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr_t1;
    avs_write && avs_waitrequest && avs_address == mte_pkg::BA_CLAMP_RELEASE_TIME
      && avs_byteenable[0] ##1 avs_write && !avs_waitrequest;
  endsequence

  sequence s_rd_t4;
    avs_read && avs_waitrequest && avs_address == mte_pkg::BA_CLAMP_RECONNECT_TIME
      ##1 avs_read && !avs_waitrequest;
  endsequence

  a_wr_store: assert property (s_wr_t1 |=> t1_q == $past(avs_writedata[7:0]))
    else $error("time register write not stored");
  a_rd_back: assert property (s_rd_t4 |-> avs_readdata == {24'h000000, t4_q})
    else $error("time register read mismatch");
  a_rel_time: assert property (fire[0] |-> cnt_q == {1'b0, t1_q[3:0]} && active_q)
    else $error("clamp release at wrong count");
  a_rel_level: assert property (fire[0] && !fire[5] |=> clamp_released)
    else $error("clamp not released");
  a_sup_start: assert property (fire[1] && !fire[4] |=> on_mod_supply && cnt_q >= {1'b0, t2_q[7:4]})
    else $error("modulation supply not selected");
  a_res_change: assert property (start ##1 (active_q && cnt_q == {1'b0, t2_q[3:0]})
      ##0 !done[2] |=> mod_resistance)
    else $error("resistance did not change");
  a_drv_stop: assert property (fire[3] |-> cnt_q == {1'b0, t3_q[7:4]} ##1 driver_stopped)
    else $error("driver not stopped");
  a_rf_return: assert property (fire[4] |=> !on_mod_supply)
    else $error("driver not back on RF supply");
  a_clamp_back: assert property (fire[5] |-> cnt_q == {1'b0, t4_q[3:0]} ##1 !clamp_released)
    else $error("clamp not reconnected");
  a_fire_once: assert property (fire[0] |=> !fire[0] ##1 ($past(start) || !fire[0]))
    else $error("event fired twice");
  a_cnt_restart: assert property (start |=> cnt_q == 5'h00 && seq_active)
    else $error("counter did not restart");

  // A restart clears every done flag, so each event can fire again
  sequence s_pulse_start;
    start ##1 (active_q && cnt_q == 5'h00);
  endsequence

  a_rearm_all: assert property (s_pulse_start |-> done == '0)
    else $error("events not rearmed at pulse start");
  a_tick_count: assert property (active_q && !start && fc_tick
      && cnt_q != mte_pkg::CNT_MAX |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("carrier period not counted");
  a_seq_end: assert property (active_q && !start && &(done | fire) |=> !seq_active)
    else $error("sequence did not end after last event");
  a_res_hold: assert property (mod_resistance && !start |=> mod_resistance)
    else $error("modulation resistance dropped early");
  a_stop_hold: assert property (driver_stopped && !start |=> driver_stopped)
    else $error("driver restarted early");
  a_masked_write: assert property (avs_write && !avs_waitrequest
      && !avs_byteenable[0] |=> $stable({t1_q, t2_q, t3_q, t4_q}))
    else $error("masked write changed a time register");

endmodule

`default_nettype wire

// *** mte_top_tb.sv ***
// Self-checking testbench for the modulation edge timing block
`timescale 1ns/1ps
`default_nettype none

module mte_top_tb;
  logic        clk;
  logic        rst_b;
  logic [8:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mod_pulse_in;
  logic        fc_tick;
  logic [4:0]  outs;
  logic [4:0]  last;
  logic [31:0] rd;
  logic [7:0]  v;
  logic [3:0]  r, ss, dr, t, rt, c;
  int          errors;
  int          check_count;
  int          ticks;
  int          ph;
  int          rise_at[5];
  int          fall_at[5];

  mte_top mte_top_inst (
    .clk             (clk),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .mod_pulse_in    (mod_pulse_in),
    .fc_tick         (fc_tick),
    .clamp_released  (outs[0]),
    .on_mod_supply   (outs[1]),
    .mod_resistance  (outs[2]),
    .driver_stopped  (outs[3]),
    .seq_active      (outs[4])
  );

  // ----------------------------------------------------------------
  // Clock, carrier ticks and event timing monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Ticks 16 cycles apart keep the pulse start well clear of any tick
  always @(posedge clk) begin
    ph <= (ph + 1) % 16;
    fc_tick <= (ph == 15);
  end

  always @(posedge clk) begin
    if (outs[4] === 1'b1 && fc_tick === 1'b1) ticks++;
    for (int i = 0; i < 5; i++) begin
      if (outs[i] !== last[i]) begin
        if (outs[i] === 1'b1) rise_at[i] = ticks;
        else fall_at[i] = ticks;
      end
    end
    last = outs;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic bus_write(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  function automatic int max6(input int a, b, c2, d, e, f);
    int m;
    m = a;
    if (b > m) m = b;
    if (c2 > m) m = c2;
    if (d > m) m = d;
    if (e > m) m = e;
    if (f > m) m = f;
    return m;
  endfunction

  task automatic run_pulse();
    int n;
    bus_write(9'h0d0, {28'h0, r});
    bus_write(9'h0d4, {24'h0, ss, dr});
    bus_write(9'h0d8, {24'h0, t, rt});
    bus_write(9'h0dc, {28'h0, c});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ph != 0 && n < 40);
    @(negedge clk);
    ticks = 0;
    rise_at = '{default: -1};
    fall_at = '{default: -1};
    @(posedge clk);
    mod_pulse_in <= 1'b1;
    for (n = 0; n < 800 && fall_at[4] == -1; n++) begin
      @(posedge clk);
      if (n == 20) mod_pulse_in <= 1'b0;
    end
    if (n >= 800) begin
      errors++;
      print_verdict();
    end
    repeat (24) @(posedge clk);
    mod_pulse_in <= 1'b0;
    check(rise_at[0], r);
    check(fall_at[0], c);
    check(rise_at[1], ss);
    check(fall_at[1], rt);
    check(rise_at[2], dr);
    check(rise_at[3], t);
    check(fall_at[4], max6(r, ss, dr, t, rt, c));
    // Every event has fired: clamp back, RF supply, resistance and stop held
    bus_read(9'h100, rd);
    check(rd, 32'h0000_000c);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    avs_address = 9'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h1;
    avs_writedata = 32'h0;
    mod_pulse_in = 1'b0;
    fc_tick = 1'b0;
    ph = 0;
    last = 5'h00;
    errors = 0;
    check_count = 0;
    rd = $urandom(46168);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus_read(9'h0d0 + 9'(4 * i), rd);
      check(rd, 32'h0);
    end
    bus_write(9'h0e0, 32'h0000_00ff);
    bus_read(9'h0e0, rd);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & ((i == 0 || i == 3) ? 8'h0f : 8'hff);
      bus_write(9'h0d0 + 9'(4 * i), {24'h0, v});
      bus_read(9'h0d0 + 9'(4 * i), rd);
      check(rd, {24'h0, v});
    end
    // A write with the low lane disabled must leave the register alone
    avs_byteenable <= 4'h0;
    bus_write(9'h0dc, {24'h0, ~v & 8'h0f});
    bus_read(9'h0dc, rd);
    check(rd, {24'h0, v});
    avs_byteenable <= 4'h1;
    {r, ss, dr, t, rt, c} = {4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1};
    run_pulse();
    {r, ss, dr, t, rt, c} = {4'he, 4'he, 4'hf, 4'hf, 4'hf, 4'hf};
    run_pulse();
    repeat (6) begin
      r = 4'($urandom_range(14));
      ss = 4'($urandom_range(r));
      c = 4'($urandom_range(15, r + 1));
      rt = 4'($urandom_range(15, ss + 1));
      dr = 4'($urandom_range(15));
      t = 4'($urandom_range(15));
      run_pulse();
    end
    print_verdict();
  end
endmodule

`default_nettype wire
